// [haptic_pkg.sv]
// Shared constants, types and state record for the haptic playback sequencer
package haptic_pkg;

   // -----------------------------------------------------------------
   // Clock and time base
   // -----------------------------------------------------------------
   localparam longint unsigned CLK_HZ = 40_000_000;
   localparam longint unsigned PWM_FREQ_HZ = 187_500;
   localparam logic [7:0] PWM_CYC = 8'(CLK_HZ / PWM_FREQ_HZ);

   // Times in microseconds
   localparam longint unsigned BOOT_US = 1_500;
   localparam longint unsigned WAKE_US = 750;
   localparam longint unsigned CLICK_DRIVE_US = 25_000;
   localparam longint unsigned CLICK_BRAKE_US = 10_000;
   localparam longint unsigned CLICK_SILENCE_US = 20_000;
   localparam longint unsigned TIMEOUT_US = 60_000_000;

   // Resonance tracking window in hertz
   localparam longint unsigned LRA_MIN_HZ = 150;
   localparam longint unsigned LRA_NOM_HZ = 200;
   localparam longint unsigned LRA_MAX_HZ = 250;
   localparam logic [17:0] HALF_MIN_CYC = 18'(CLK_HZ / (2 * LRA_MAX_HZ));
   localparam logic [17:0] HALF_NOM_CYC = 18'(CLK_HZ / (2 * LRA_NOM_HZ));
   localparam logic [17:0] HALF_MAX_CYC = 18'(CLK_HZ / (2 * LRA_MIN_HZ));

   // Drive levels and supply headroom in millivolts
   localparam logic [12:0] HIGH_LEVEL_MV = 13'h0708;
   localparam logic [12:0] LOW_LEVEL_MV = 13'h03e8;
   localparam logic [12:0] HEADROOM_MV = 13'h0460;

   // -----------------------------------------------------------------
   // Time conversion
   // -----------------------------------------------------------------
   // Longest time: round down, never below one cycle
   function automatic logic [31:0] us_to_cyc_floor(input longint unsigned us);
      longint unsigned c;
      c = (us * CLK_HZ) / 64'd1_000_000;
      if (c == 64'd0) begin
         c = 64'd1;
      end
      return c[31:0];
   endfunction

   // Least time: round up, never below one cycle
   function automatic logic [31:0] us_to_cyc_ceil(input longint unsigned us);
      longint unsigned c;
      c = (us * CLK_HZ + 64'd999_999) / 64'd1_000_000;
      if (c == 64'd0) begin
         c = 64'd1;
      end
      return c[31:0];
   endfunction

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF, ST_BOOT, ST_IDLE, ST_WAKE, ST_DRIVE, ST_BRAKE, ST_SILENCE
   } seq_state_t;

   typedef enum logic [1:0] {EFF_CLICK, EFF_STRONG, EFF_MEDIUM} effect_t;

   typedef struct packed {
      logic undervoltage_lockout;
      logic over_temp;
      logic bridge_short;
      logic impedance_fault;
   } fault_t;

   typedef struct packed {
      seq_state_t st;
      effect_t eff;
      logic [31:0] tmr;
      logic [2:0] trg_s1;
      logic [2:0] trg_s2;
      logic [2:0] trg_s3;
      logic emf_s1;
      logic emf_s2;
      logic emf_s3;
      logic [7:0] pwm_cnt;
      logic [7:0] duty;
      logic pol;
      logic [17:0] half_cnt;
      logic [17:0] learned_half;
      logic learned_valid;
      logic [12:0] level_mv;
      logic out_pos;
      logic out_neg;
      logic out_oe;
   } seq_regs_t;

   localparam seq_regs_t SEQ_RESET = '{
      st: ST_OFF, eff: EFF_CLICK, tmr: 32'h0000_0000,
      trg_s1: 3'h7, trg_s2: 3'h7, trg_s3: 3'h7,
      emf_s1: 1'b0, emf_s2: 1'b0, emf_s3: 1'b0,
      pwm_cnt: 8'h00, duty: 8'h00, pol: 1'b0,
      half_cnt: 18'h00000, learned_half: HALF_NOM_CYC, learned_valid: 1'b0,
      level_mv: 13'h0000, out_pos: 1'b0, out_neg: 1'b0, out_oe: 1'b0
   };

endpackage

// [gpi_haptic_playback_sequencer.sv]
// Pin-controlled playback sequencer for a resonant actuator H-bridge driver
`timescale 1ns/1ps
`default_nettype none

module gpi_haptic_playback_sequencer
   import haptic_pkg::*;
#(
   parameter logic [31:0] BOOT_CYC = us_to_cyc_floor(BOOT_US),
   parameter logic [31:0] WAKE_CYC = us_to_cyc_floor(WAKE_US),
   parameter logic [31:0] CLICK_DRIVE_CYC = us_to_cyc_floor(CLICK_DRIVE_US),
   parameter logic [31:0] CLICK_BRAKE_CYC = us_to_cyc_floor(CLICK_BRAKE_US),
   parameter logic [31:0] CLICK_SILENCE_CYC = us_to_cyc_floor(CLICK_SILENCE_US),
   parameter logic [31:0] TIMEOUT_CYC = us_to_cyc_floor(TIMEOUT_US)
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic supply_enable_pin,
   input wire logic click_trigger_in,
   input wire logic strong_buzz_trigger_in,
   input wire logic medium_buzz_trigger_in,
   input wire fault_t faults,
   input wire logic back_emf_sense,
   input wire logic [12:0] vdd_mv,
   input wire logic [12:0] load_level_mv,
   output logic bridge_out_pos,
   output logic bridge_out_neg,
   output logic bridge_oe,
   output seq_state_t seq_state,
   output logic [12:0] drive_level_mv,
   output logic learned_valid
);

   // -----------------------------------------------------------------
   // Interface notes
   // -----------------------------------------------------------------
   // Triggers idle high; the three-deep chain adds two cycles per edge.
   // Fault flags are levels from analog comparators; they are not
   // latched, so a fault that clears before the next trigger allows
   // an immediate retry.
   // Supply and load levels are sampled values in millivolts; a slow
   // update rate only delays the amplitude cap by that much.
   // Both bridge legs mean something only while the enable is high;
   // they are held low whenever the bridge is released.
   // The reported level is the target, not the measured one.
   // Limitation: no minimum buzz length is enforced, that is the
   // host's timing duty.

   // -----------------------------------------------------------------
   // Helper functions
   // -----------------------------------------------------------------

   // Pure decode only, no state; shared by the start path and the
   // per-cycle amplitude update so both agree on the same level

   // Lowest-numbered falling edge wins when several land together
   function automatic effect_t pick_effect(input logic [2:0] fall);
      effect_t e;
      e = EFF_MEDIUM;
      if (fall[0]) begin
         e = EFF_CLICK;
      end else if (fall[1]) begin
         e = EFF_STRONG;
      end
      return e;
   endfunction

   // Nominal level of an effect, trimmed to stay clear of the supply rail
   function automatic logic [12:0] limited_level(input effect_t e,
                                                 input logic [12:0] vdd);
      logic [12:0] nominal;
      logic [12:0] ceiling;
      nominal = (e == EFF_MEDIUM) ? LOW_LEVEL_MV : HIGH_LEVEL_MV;
      ceiling = (vdd > HEADROOM_MV) ? vdd - HEADROOM_MV : 13'h0000;
      return (nominal < ceiling) ? nominal : ceiling;
   endfunction

   // Duration of the first drive phase of an effect
   function automatic logic [31:0] drive_len(input effect_t e);
      return (e == EFF_CLICK) ? CLICK_DRIVE_CYC - 32'd1 : TIMEOUT_CYC - 32'd1;
   endfunction

   // -----------------------------------------------------------------
   // State record
   // -----------------------------------------------------------------
   seq_regs_t q;
   seq_regs_t d;

   // Decode of the registered record, shared by every branch below.
   // Kept apart from the next-state process so each term is computed
   // once; every term but the fault OR reads only flops, never the raw pins.
   logic [2:0] trg_fall;
   logic any_fall;
   logic any_fault;
   logic emf_cross;
   logic tmr_done;
   logic pwm_wrap;
   logic pwm_high;
   logic playing;

   // Edge decode from registered copies; fault decode straight from the raw flags
   always_comb begin
      trg_fall = q.trg_s3 & ~q.trg_s2;
      any_fall = |trg_fall;
      any_fault = |faults;
      emf_cross = q.emf_s3 ^ q.emf_s2;
      tmr_done = (q.tmr == 32'h0000_0000);
      pwm_wrap = (q.pwm_cnt == PWM_CYC - 8'h01);
      pwm_high = (q.pwm_cnt < q.duty);
      playing = (q.st == ST_WAKE) || (q.st == ST_DRIVE) ||
                (q.st == ST_BRAKE) || (q.st == ST_SILENCE);
   end

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   // One process carries every register so the OFF discard stays complete
   always_comb begin
      d = q;

      // Two flops per input, a third only as the edge reference
      d.trg_s1 = {medium_buzz_trigger_in, strong_buzz_trigger_in,
                  click_trigger_in};
      d.trg_s2 = q.trg_s1;
      d.trg_s3 = q.trg_s2;
      d.emf_s1 = back_emf_sense;
      d.emf_s2 = q.emf_s1;
      d.emf_s3 = q.emf_s2;

      // Timer counts down to zero in every timed state
      if (!tmr_done) begin
         d.tmr = q.tmr - 32'd1;
      end

      // PWM carrier free-runs at the switching rate
      d.pwm_cnt = pwm_wrap ? 8'h00 : q.pwm_cnt + 8'h01;

      // Bridge idles released unless a drive state says otherwise
      d.out_oe = 1'b0;
      d.out_pos = 1'b0;
      d.out_neg = 1'b0;

      // Sequencer flow:
      //   OFF     - one cycle, then boot timer loaded
      //   BOOT    - trigger edges ignored until settings are loaded
      //   IDLE    - waits for the first falling edge
      //   WAKE    - fixed start latency, bridge still released
      //   DRIVE   - bridge switching; click ends by timer, buzz by
      //             stop edge or timeout
      //   BRAKE   - click only, antiphase drive
      //   SILENCE - click only, bridge released
      // Timers load one below the length: exit is the edge after zero
      case (q.st)
         ST_OFF: begin
            d.st = ST_BOOT;
            d.tmr = BOOT_CYC - 32'd1;
         end

         // Edges during boot are not yet requests
         ST_BOOT: begin
            if (tmr_done) begin
               d.st = ST_IDLE;
            end
         end

         ST_IDLE: begin
            // Several edges in one cycle are a single request
            if (any_fall) begin
               d.st = ST_WAKE;
               d.eff = pick_effect(trg_fall);
               d.tmr = WAKE_CYC - 32'd1;
            end
         end

         // Wake latency before the bridge starts switching
         ST_WAKE: begin
            if (tmr_done) begin
               d.st = ST_DRIVE;
               d.tmr = drive_len(q.eff);
               d.duty = 8'h00;
               d.half_cnt = 18'h00000;
               // Level fixed from the supply seen at wake exit; the
               // drive engine refreshes it every cycle afterwards
               d.level_mv = limited_level(q.eff, vdd_mv);
            end
         end

         ST_DRIVE: begin
            if (tmr_done) begin
               if (q.eff == EFF_CLICK) begin
                  d.st = ST_BRAKE;
                  d.tmr = CLICK_BRAKE_CYC - 32'd1;
               end else begin
                  // A buzz reaching its timer end is the host-loss guard
                  d.st = ST_IDLE;
               end
            end
         end

         // Brake drives in antiphase to the tracked motion
         ST_BRAKE: begin
            if (tmr_done) begin
               d.st = ST_SILENCE;
               d.tmr = CLICK_SILENCE_CYC - 32'd1;
            end
         end

         ST_SILENCE: begin
            // Bridge stays released through the defaults above
            if (tmr_done) begin
               d.st = ST_IDLE;
            end
         end

         default: begin
            // Unused encoding recovers through OFF
            d.st = ST_OFF;
         end
      endcase

      // Stop edge or fault beats any timed transition
      // Placed after the case so a stop or fault in the same cycle as a
      // timer expiry always lands in IDLE; nothing is latched, so the
      // next trigger simply retries.
      if (playing && (any_fall || any_fault)) begin
         d.st = ST_IDLE;
         d.duty = 8'h00;
         d.level_mv = 13'h0000;
      end

      // -------------------------------------------------------------
      // Drive engine while the bridge is active
      // -------------------------------------------------------------
      if ((q.st == ST_DRIVE || q.st == ST_BRAKE) && d.st == q.st) begin
         // Supply followed each cycle, not just at start
         d.level_mv = limited_level(q.eff, vdd_mv);

         // Current loop: nudge duty toward the target once per period
         // One step per carrier period keeps the loop slow against the
         // switching ripple; the ramp from zero is traded for stability
         if (pwm_wrap) begin
            if (load_level_mv < q.level_mv && q.duty < PWM_CYC - 8'h01) begin
               d.duty = q.duty + 8'h01;
            end else if (load_level_mv > q.level_mv && q.duty != 8'h00) begin
               d.duty = q.duty - 8'h01;
            end
         end

         // Resonance tracking runs alongside drive, no sense gaps
         // Counter clears at the learned half period at the latest, so
         // 18 bits cover the slowest plausible resonance
         d.half_cnt = q.half_cnt + 18'h00001;
         if (emf_cross) begin
            d.half_cnt = 18'h00000;
            d.pol = ~q.pol;
            // Only plausible periods teach the tracker
            if (q.half_cnt >= HALF_MIN_CYC && q.half_cnt <= HALF_MAX_CYC) begin
               d.learned_half = q.half_cnt;
               d.learned_valid = 1'b1;
            end
         end else if (q.half_cnt >= q.learned_half) begin
            // No crossing seen: flip on the learned half period
            d.half_cnt = 18'h00000;
            d.pol = ~q.pol;
         end

         // Differential switching; brake inverts the phase
         d.out_oe = 1'b1;
         if (q.pol ^ (q.st == ST_BRAKE)) begin
            d.out_pos = pwm_high;
         end else begin
            d.out_neg = pwm_high;
         end
      end

      // Faults release the bridge the same cycle they are seen
      // Comparators may fire outside playback; releasing is harmless
      if (any_fault) begin
         d.out_oe = 1'b0;
         d.out_pos = 1'b0;
         d.out_neg = 1'b0;
      end

      // Enable low discards all, learned setup included
      // Applied last so nothing above can leak through; the bridge is
      // released at the first edge that sees the pin low
      if (!supply_enable_pin) begin
         d = SEQ_RESET;
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   // Clock enable freezes everything, including the synchronisers
   // Reset is synchronous but does not wait for the clock enable, so
   // any edge that sees it high clears the record
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q <= SEQ_RESET;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // All taken straight from the state record
   // No logic between record and pins keeps output timing clean and
   // avoids glitches on the bridge gate drivers
   assign bridge_out_pos = q.out_pos;
   assign bridge_out_neg = q.out_neg;
   assign bridge_oe = q.out_oe;
   assign seq_state = q.st;
   assign drive_level_mv = q.level_mv;
   assign learned_valid = q.learned_valid;

endmodule

`default_nettype wire

// [gpi_haptic_playback_sequencer_monitor.sv]
// Port-level assertions for the playback sequencer, bound to the design
`timescale 1ns/1ps
`default_nettype none

module gpi_haptic_playback_sequencer_monitor
   import haptic_pkg::*;
#(
   parameter int BOOT_N = 20,
   parameter int WAKE_N = 10,
   parameter int BRK_N = 200,
   parameter int SIL_N = 250,
   parameter int TMO_N = 900
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic supply_enable_pin,
   input wire fault_t faults,
   input wire logic [12:0] vdd_mv,
   input wire logic bridge_out_pos,
   input wire logic bridge_out_neg,
   input wire logic bridge_oe,
   input wire seq_state_t seq_state,
   input wire logic [12:0] drive_level_mv,
   input wire logic learned_valid
);
   // ---------------------------------------------------------------
   // Properties, one clock domain
   // ---------------------------------------------------------------
   default clocking mon_cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   property p_off;
      !supply_enable_pin |=> seq_state == ST_OFF && !bridge_oe && !learned_valid;
   endproperty
   a_off: assert property (p_off) else $error("no OFF with enable low");
   property p_keep;
      learned_valid && supply_enable_pin |=> learned_valid;
   endproperty
   a_keep: assert property (p_keep) else $error("learned setup lost");
   property p_boot;
      $rose(seq_state == ST_BOOT) |-> ##BOOT_N seq_state == ST_IDLE;
   endproperty
   a_boot: assert property (p_boot) else $error("boot length wrong");
   property p_wake;
      $rose(seq_state == ST_WAKE) |-> ##WAKE_N seq_state == ST_DRIVE;
   endproperty
   a_wake: assert property (p_wake) else $error("wake delay wrong");
   property p_tail;
      $rose(seq_state == ST_BRAKE) |-> ##BRK_N seq_state == ST_SILENCE ##SIL_N seq_state == ST_IDLE;
   endproperty
   a_tail: assert property (p_tail) else $error("click tail wrong");
   property p_tmo;
      $rose(seq_state == ST_DRIVE) |-> ##[1:TMO_N] seq_state != ST_DRIVE;
   endproperty
   a_tmo: assert property (p_tmo) else $error("drive outlived timeout");
   property p_oe_on;
      $rose(seq_state == ST_DRIVE) && faults == '0 |=> bridge_oe;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("bridge not driven");
   // Faults cut the bridge at the very edge that leaves DRIVE
   property p_fault;
      faults != '0 && seq_state == ST_DRIVE |=>
         seq_state == ST_IDLE && !bridge_oe && !bridge_out_pos && !bridge_out_neg;
   endproperty
   a_fault: assert property (p_fault) else $error("fault not cancelled");
   property p_idle_hiz;
      seq_state == ST_IDLE && $past(seq_state == ST_IDLE) |-> !bridge_oe;
   endproperty
   a_idle_hiz: assert property (p_idle_hiz) else $error("bridge on in IDLE");
   // Stable supply only: level lags a supply step by one register
   property p_cap;
      seq_state == ST_DRIVE && $past(seq_state == ST_DRIVE) && $stable(vdd_mv)
         && vdd_mv >= HEADROOM_MV |-> drive_level_mv <= vdd_mv - HEADROOM_MV;
   endproperty
   a_cap: assert property (p_cap) else $error("level above supply cap");
endmodule

bind gpi_haptic_playback_sequencer gpi_haptic_playback_sequencer_monitor #(.BOOT_N(BOOT_CYC),
   .WAKE_N(WAKE_CYC), .BRK_N(CLICK_BRAKE_CYC), .SIL_N(CLICK_SILENCE_CYC), .TMO_N(TIMEOUT_CYC))
   i_mon (.sys_clk(sys_clk), .rst(rst), .supply_enable_pin(supply_enable_pin), .faults(faults),
   .vdd_mv(vdd_mv), .bridge_out_pos(bridge_out_pos), .bridge_out_neg(bridge_out_neg),
   .bridge_oe(bridge_oe), .seq_state(seq_state), .drive_level_mv(drive_level_mv),
   .learned_valid(learned_valid));
`default_nettype wire

// [host_trigger_model.sv]
// Host controller model pulsing the three trigger lines
`timescale 1ns/1ps
`default_nettype none

module host_trigger_model (
   input wire logic sys_clk,
   input wire logic [2:0] fire,
   output logic [2:0] trig
);
   int hold_cnt = 0;

   // Lines idle high; requested lines fall, all rise together later
   always @(negedge sys_clk) begin
      if (fire != 3'h0) begin
         trig <= trig & ~fire;
         hold_cnt <= 32'h3e9;
      end else if (hold_cnt != 0) begin
         hold_cnt <= hold_cnt - 1;
         if (hold_cnt == 1) begin
            trig <= 3'h7;
         end
      end else begin
         trig <= 3'h7;
      end
   end
endmodule
`default_nettype wire

// [gpi_haptic_playback_sequencer_tb_top.sv]
// Self-checking testbench for the playback sequencer
`timescale 1ns/1ps
`default_nettype none

module gpi_haptic_playback_sequencer_tb_top;
   import haptic_pkg::*;
   // Shortened counts keep the run brief
   localparam logic [31:0] BOOT_N = 32'h14;
   localparam logic [31:0] WAKE_N = 32'ha;
   localparam logic [31:0] DRV_N = 32'h12c;
   localparam logic [31:0] BRK_N = 32'hc8;
   localparam logic [31:0] SIL_N = 32'hfa;
   localparam logic [31:0] TMO_N = 32'h384;
   logic sys_clk, rst, supply_enable_pin, bridge_out_pos, bridge_out_neg, bridge_oe;
   logic learned_valid;
   logic [2:0] trig, host_fire;
   fault_t faults;
   logic [12:0] vdd_mv, drive_level_mv;
   seq_state_t seq_state;
   int error_cnt, n_tests;

   gpi_haptic_playback_sequencer #(.BOOT_CYC(BOOT_N), .WAKE_CYC(WAKE_N), .CLICK_DRIVE_CYC(DRV_N),
      .CLICK_BRAKE_CYC(BRK_N), .CLICK_SILENCE_CYC(SIL_N), .TIMEOUT_CYC(TMO_N)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .supply_enable_pin(supply_enable_pin),
      .click_trigger_in(trig[0]), .strong_buzz_trigger_in(trig[1]),
      .medium_buzz_trigger_in(trig[2]), .faults(faults), .back_emf_sense(1'b0),
      .vdd_mv(vdd_mv), .load_level_mv(13'h0000), .bridge_out_pos(bridge_out_pos),
      .bridge_out_neg(bridge_out_neg), .bridge_oe(bridge_oe), .seq_state(seq_state),
      .drive_level_mv(drive_level_mv), .learned_valid(learned_valid));
   host_trigger_model i_host (.sys_clk(sys_clk), .fire(host_fire), .trig(trig));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task chk_n(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task chk_st(input string what, input seq_state_t exp);
      n_tests++;
      if (seq_state !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %0d seen %0d", what, exp, seq_state);
      end
   endtask
   // Bounded wait; returns cycles spent
   task wait_st(input seq_state_t s, output int n);
      n = 0;
      while (seq_state !== s && n < 4000) begin
         @(negedge sys_clk);
         n++;
      end
   endtask
   task fire(input logic [2:0] m);
      @(posedge sys_clk);
      host_fire <= m;
      @(posedge sys_clk);
      host_fire <= 3'h0;
      @(negedge sys_clk);
   endtask
   // Outlasts the host pulse so every line is high again
   task settle;
      repeat (1100) @(negedge sys_clk);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_click;
      int n;
      fire(3'h1);
      wait_st(ST_WAKE, n);
      wait_st(ST_DRIVE, n);
      chk_n("wake length", WAKE_N, n);
      @(negedge sys_clk);
      chk_n("click level", 32'(HIGH_LEVEL_MV), 32'(drive_level_mv));
      chk_n("bridge on", 32'h1, 32'(bridge_oe));
      wait_st(ST_BRAKE, n);
      chk_n("drive length", DRV_N - 1, n);
      wait_st(ST_SILENCE, n);
      chk_n("brake length", BRK_N, n);
      wait_st(ST_IDLE, n);
      chk_n("silence length", SIL_N, n);
      settle;
      $display("click test done");
   endtask
   task t_stop;
      int n;
      fire(3'h2);
      wait_st(ST_DRIVE, n);
      @(negedge sys_clk);
      chk_n("strong level", 32'(HIGH_LEVEL_MV), 32'(drive_level_mv));
      repeat (100) @(negedge sys_clk);
      fire(3'h1);
      wait_st(ST_IDLE, n);
      chk_n("stop delay", 32'h1, 32'(n < 8));
      repeat (30) @(negedge sys_clk);
      chk_st("no restart", ST_IDLE);
      settle;
      chk_st("rise ignored", ST_IDLE);
      fire(3'h4);
      wait_st(ST_DRIVE, n);
      @(negedge sys_clk);
      chk_n("medium level", 32'(LOW_LEVEL_MV), 32'(drive_level_mv));
      wait_st(ST_IDLE, n);
      chk_n("timeout", TMO_N - 1, n);
      settle;
      $display("stop test done");
   endtask
   task t_fault_supply;
      int n;
      for (int i = 0; i < 5; i++) begin
         fire(i == 4 ? 3'h6 : 3'h2);
         wait_st(ST_DRIVE, n);
         chk_st("retry", ST_DRIVE);
         repeat (5) @(negedge sys_clk);
         if (i == 4) begin
            chk_n("tie level", 32'(HIGH_LEVEL_MV), 32'(drive_level_mv));
            vdd_mv <= 13'h07d0;
            repeat (4) @(negedge sys_clk);
            chk_n("capped", 32'h370, 32'(drive_level_mv));
            vdd_mv <= 13'h0ed8;
            fire(3'h1);
         end else begin
            faults <= fault_t'(4'h1 << i);
            @(negedge sys_clk);
            faults <= '0;
            chk_st("fault cancel", ST_IDLE);
            chk_n("bridge off", 32'h0, 32'({bridge_oe, bridge_out_pos, bridge_out_neg}));
         end
         settle;
      end
      $display("fault and supply test done");
   endtask
   task t_enable;
      int n;
      supply_enable_pin <= 1'b0;
      repeat (2) @(negedge sys_clk);
      chk_st("off state", ST_OFF);
      chk_n("setup lost", 32'h0, 32'(learned_valid));
      supply_enable_pin <= 1'b1;
      fire(3'h1);
      wait_st(ST_IDLE, n);
      repeat (30) @(negedge sys_clk);
      chk_st("boot edge ignored", ST_IDLE);
      $display("enable test done");
   endtask

   task finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Runs need about 11000 cycles
   initial begin
      repeat (40000) @(posedge sys_clk);
      error_cnt++;
      finish_test;
   end

   initial begin
      int n;
      rst = 1'b1;
      supply_enable_pin = 1'b1;
      faults = '0;
      vdd_mv = 13'h0ed8;
      host_fire = 3'h0;
      error_cnt = 0;
      n_tests = 0;
      repeat (20) @(negedge sys_clk);
      chk_st("reset state", ST_OFF);
      rst <= 1'b0;
      wait_st(ST_IDLE, n);
      chk_n("boot time", BOOT_N + 1, n);
      t_click;
      t_stop;
      t_fault_supply;
      t_enable;
      finish_test;
   end
endmodule
`default_nettype wire
